/* design/dtm_dual_timer.sv */
// two counter/timers with mode, source and gate selection
// Overview of operation
// - second timer with pin qualify clear counts whenever its run bit is set and its mode field is not 3 (inactive).
// - second timer with pin qualify set counts only while run and its irq pin is at the active level, except while first is split.
// - first timer with pin qualify clear counts whenever its run bit is set.
// - first timer with pin qualify set counts only while run and its irq pin is at the active level.
// - second source select 0 counts the selected clock, 1 counts falling edges on its count pin.
// - first source select 0 counts the selected clock, 1 counts falling edges on its count pin.
// - second mode field picks 13-bit, 16-bit, 8-bit reload, or inactive.
// - first mode field picks 13-bit, 16-bit, 8-bit reload, or split into two 8-bit timers.
// - first low count is a read/write byte, reset zero, low half of the count.
// - second low count is a read/write byte, reset zero, low half of the count.
// - in 8-bit reload mode a low byte wrap sets the overflow flag and reloads from the high byte.
// - in split mode the first high byte counts the clock, runs on the second run bit, sets the second flag.
// - while first is split, second still counts in modes 0-2 but takes no pin edges and sets no flag.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module dtm_dual_timer
    import dtm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdData,
    // pins
    input wire logic firstCountPin,
    input wire logic secondCountPin,
    input wire logic firstExternalIrqPin,
    input wire logic secondExternalIrqPin,
    // status
    output logic firstTimerOverflowFlag,
    output logic secondTimerOverflowFlag,
    output logic timerIrq
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] timerModeSelect_reg;
    logic [7:0] firstTimerLowCount_reg;
    logic [7:0] secondTimerLowCount_reg;
    logic [7:0] firstTimerHighCount_reg;
    logic [7:0] secondTimerHighCount_reg;
    logic [7:0] timerOptions_reg;
    logic firstTimerRun_reg;
    logic secondTimerRun_reg;
    logic [IRQ_W-1:0] irqStatus_reg;
    logic [IRQ_W-1:0] irqMask_reg;

    ////////////////////////////////////////////////////////////////////////
    // pin conditioning and prescaler
    logic firstCountFall;
    logic secondCountFall;
    logic firstIrqLevel;
    logic secondIrqLevel;
    logic prescaleTick;

    dtm_pin_sync firstCountSync (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(firstCountPin),
        .pinLevel(), .pinFall(firstCountFall)
    );
    dtm_pin_sync secondCountSync (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(secondCountPin),
        .pinLevel(), .pinFall(secondCountFall)
    );
    dtm_pin_sync firstIrqSync (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(firstExternalIrqPin),
        .pinLevel(firstIrqLevel), .pinFall()
    );
    dtm_pin_sync secondIrqSync (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .pinIn(secondExternalIrqPin),
        .pinLevel(secondIrqLevel), .pinFall()
    );
    dtm_prescaler prescaler (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .tickPulse(prescaleTick)
    );

    ////////////////////////////////////////////////////////////////////////
    // field decode
    dtm_mode_t firstMode;
    dtm_mode_t secondMode;
    logic firstSplit;
    logic firstActive;
    logic secondActive;
    logic firstClockTick;
    logic secondClockTick;
    logic firstInc;
    logic secondInc;
    logic splitHighInc;

    assign firstMode = dtm_mode_t'(
        timerModeSelect_reg[FIRST_MODE_HI:FIRST_MODE_LO]);
    assign secondMode = dtm_mode_t'(
        timerModeSelect_reg[SECOND_MODE_HI:SECOND_MODE_LO]);
    assign firstSplit = (firstMode == MODE_SPLIT);

    // gate: run bit, optionally qualified by the irq pin level
    assign firstActive = firstTimerRun_reg &
        (~timerModeSelect_reg[FIRST_PIN_QUALIFY_BIT] |
         (firstIrqLevel == timerOptions_reg[FIRST_IRQ_POLARITY_BIT]));
    // in split mode the second timer runs through its own mode setting
    assign secondActive = firstSplit ? (secondMode != MODE_SPLIT) :
        (secondTimerRun_reg & (secondMode != MODE_SPLIT) &
         (~timerModeSelect_reg[SECOND_PIN_QUALIFY_BIT] |
          (secondIrqLevel ==
           timerOptions_reg[SECOND_IRQ_POLARITY_BIT])));

    assign firstClockTick = timerOptions_reg[FIRST_PRESCALE_BIT] ?
        1'b1 : prescaleTick;
    assign secondClockTick = timerOptions_reg[SECOND_PRESCALE_BIT] ?
        1'b1 : prescaleTick;

    assign firstInc = firstActive &
        (timerModeSelect_reg[FIRST_SOURCE_SELECT_BIT] ?
         firstCountFall : firstClockTick);
    assign secondInc = secondActive &
        ((timerModeSelect_reg[SECOND_SOURCE_SELECT_BIT] & ~firstSplit) ?
         secondCountFall : secondClockTick);
    assign splitHighInc = firstSplit & secondTimerRun_reg &
        firstClockTick;

    ////////////////////////////////////////////////////////////////////////
    // count next-state logic, shared by both timers
    function automatic logic [16:0] dtm_step(
        input dtm_mode_t mode,
        input logic [7:0] low,
        input logic [7:0] high
    );
        logic [16:0] res;
        res = {1'b0, high, low};
        case (mode)
            MODE_13BIT: begin
                if (low[4:0] == PRESCALE_ALL_ONES) begin
                    res[7:0] = {low[7:5], 5'h00};
                    res[15:8] = high + 8'h01;
                    res[16] = (high == BYTE_ALL_ONES);
                end else begin
                    res[7:0] = low + 8'h01;
                end
            end
            MODE_16BIT: begin
                res[16:0] = {1'b0, high, low} + 17'h00001;
            end
            MODE_8BIT_RELOAD, MODE_SPLIT: begin
                if (low == BYTE_ALL_ONES) begin
                    res[7:0] = (mode == MODE_8BIT_RELOAD) ?
                        high : BYTE_RESET;
                    res[16] = 1'b1;
                end else begin
                    res[7:0] = low + 8'h01;
                end
            end
            default: begin
                res = {1'b0, high, low};
            end
        endcase
        return res;
    endfunction

    logic [16:0] firstStep;
    logic [16:0] secondStep;
    logic firstOverflow;
    logic secondOverflow;
    logic splitHighOverflow;

    assign firstStep = dtm_step(firstMode, firstTimerLowCount_reg,
        firstTimerHighCount_reg);
    assign secondStep = dtm_step(secondMode, secondTimerLowCount_reg,
        secondTimerHighCount_reg);
    assign firstOverflow = firstInc & firstStep[16];
    assign secondOverflow = secondInc & secondStep[16] & ~firstSplit;
    assign splitHighOverflow = splitHighInc &
        (firstTimerHighCount_reg == BYTE_ALL_ONES);

    ////////////////////////////////////////////////////////////////////////
    // register writes
    logic wrMode;
    logic wrCtrl;
    logic wrFirstLow;
    logic wrSecondLow;
    logic wrFirstHigh;
    logic wrSecondHigh;
    logic wrOptions;
    logic wrStatus;
    logic wrMask;

    assign wrMode = regWrite & (regAddr == TIMER_MODE_SELECT_OFS);
    assign wrCtrl = regWrite & (regAddr == TIMER_CONTROL_OFS);
    assign wrFirstLow = regWrite & (regAddr == FIRST_TIMER_LOW_COUNT_OFS);
    assign wrSecondLow = regWrite & (regAddr == SECOND_TIMER_LOW_COUNT_OFS);
    assign wrFirstHigh = regWrite & (regAddr == FIRST_TIMER_HIGH_COUNT_OFS);
    assign wrSecondHigh = regWrite & (regAddr == SECOND_TIMER_HIGH_COUNT_OFS);
    assign wrOptions = regWrite & (regAddr == TIMER_OPTIONS_OFS);
    assign wrStatus = regWrite & (regAddr == IRQ_STATUS_OFS);
    assign wrMask = regWrite & (regAddr == IRQ_MASK_OFS);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            timerModeSelect_reg <= BYTE_RESET;
            timerOptions_reg <= BYTE_RESET;
            firstTimerRun_reg <= 1'b0;
            secondTimerRun_reg <= 1'b0;
            irqMask_reg <= '0;
        end else begin
            if (wrMode) begin
                timerModeSelect_reg <= regWrData;
            end
            if (wrOptions) begin
                timerOptions_reg <= regWrData;
            end
            if (wrCtrl) begin
                firstTimerRun_reg <= regWrData[FIRST_RUN_BIT];
                secondTimerRun_reg <= regWrData[SECOND_RUN_BIT];
            end
            if (wrMask) begin
                irqMask_reg <= regWrData[IRQ_W-1:0];
            end
        end
    end

    // first timer count bytes; a software write wins over counting
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            firstTimerLowCount_reg <= BYTE_RESET;
            firstTimerHighCount_reg <= BYTE_RESET;
        end else begin
            if (wrFirstLow) begin
                firstTimerLowCount_reg <= regWrData;
            end else if (firstInc) begin
                firstTimerLowCount_reg <= firstStep[7:0];
            end
            if (wrFirstHigh) begin
                firstTimerHighCount_reg <= regWrData;
            end else if (splitHighInc) begin
                firstTimerHighCount_reg <= firstTimerHighCount_reg + 8'h01;
            end else if (firstInc & ~firstSplit) begin
                firstTimerHighCount_reg <= firstStep[15:8];
            end
        end
    end

    // second timer count bytes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            secondTimerLowCount_reg <= BYTE_RESET;
            secondTimerHighCount_reg <= BYTE_RESET;
        end else begin
            if (wrSecondLow) begin
                secondTimerLowCount_reg <= regWrData;
            end else if (secondInc) begin
                secondTimerLowCount_reg <= secondStep[7:0];
            end
            if (wrSecondHigh) begin
                secondTimerHighCount_reg <= regWrData;
            end else if (secondInc) begin
                secondTimerHighCount_reg <= secondStep[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overflow flags: hardware set wins over software clear
    logic firstSet;
    logic secondSet;

    assign firstSet = firstOverflow;
    assign secondSet = secondOverflow | splitHighOverflow;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            firstTimerOverflowFlag <= 1'b0;
            secondTimerOverflowFlag <= 1'b0;
        end else begin
            if (firstSet) begin
                firstTimerOverflowFlag <= 1'b1;
            end else if (wrCtrl) begin
                firstTimerOverflowFlag <= regWrData[FIRST_OVERFLOW_BIT];
            end
            if (secondSet) begin
                secondTimerOverflowFlag <= 1'b1;
            end else if (wrCtrl) begin
                secondTimerOverflowFlag <= regWrData[SECOND_OVERFLOW_BIT];
            end
        end
    end

    // sticky status, write one to clear, set wins
    logic [IRQ_W-1:0] irqEvents;
    assign irqEvents = {secondSet, firstSet};

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irqStatus_reg <= '0;
            timerIrq <= 1'b0;
        end else begin
            irqStatus_reg <= irqEvents |
                (irqStatus_reg & ~(wrStatus ? regWrData[IRQ_W-1:0] : '0));
            timerIrq <= |(irqStatus_reg & irqMask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            regRdData <= UNMAPPED_READ;
        end else if (regRead) begin
            case (regAddr)
                TIMER_CONTROL_OFS: begin
                    regRdData <= {secondTimerOverflowFlag, secondTimerRun_reg,
                        firstTimerOverflowFlag, firstTimerRun_reg, 4'h0};
                end
                TIMER_MODE_SELECT_OFS: regRdData <= timerModeSelect_reg;
                FIRST_TIMER_LOW_COUNT_OFS: regRdData <= firstTimerLowCount_reg;
                SECOND_TIMER_LOW_COUNT_OFS: begin
                    regRdData <= secondTimerLowCount_reg;
                end
                FIRST_TIMER_HIGH_COUNT_OFS: begin
                    regRdData <= firstTimerHighCount_reg;
                end
                SECOND_TIMER_HIGH_COUNT_OFS: begin
                    regRdData <= secondTimerHighCount_reg;
                end
                TIMER_OPTIONS_OFS: regRdData <= {4'h0, timerOptions_reg[3:0]};
                IRQ_STATUS_OFS: regRdData <= {6'h00, irqStatus_reg};
                IRQ_MASK_OFS: regRdData <= {6'h00, irqMask_reg};
                default: regRdData <= UNMAPPED_READ;
            endcase
        end else begin
            regRdData <= UNMAPPED_READ;
        end
    end
endmodule

/* design/dtm_pkg.sv */
// package: register map, field positions and constants for the timer block
package dtm_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] TIMER_CONTROL_OFS = 8'h88;
    localparam logic [7:0] TIMER_MODE_SELECT_OFS = 8'h89;
    localparam logic [7:0] FIRST_TIMER_LOW_COUNT_OFS = 8'h8a;
    localparam logic [7:0] SECOND_TIMER_LOW_COUNT_OFS = 8'h8b;
    localparam logic [7:0] FIRST_TIMER_HIGH_COUNT_OFS = 8'h8c;
    localparam logic [7:0] SECOND_TIMER_HIGH_COUNT_OFS = 8'h8d;
    localparam logic [7:0] TIMER_OPTIONS_OFS = 8'h90;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h91;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h92;
    // reset values and compare constants
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
    localparam logic [4:0] PRESCALE_ALL_ONES = 5'h1f;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // timer_mode_select fields
    localparam int SECOND_PIN_QUALIFY_BIT = 7;
    localparam int SECOND_SOURCE_SELECT_BIT = 6;
    localparam int SECOND_MODE_HI = 5;
    localparam int SECOND_MODE_LO = 4;
    localparam int FIRST_PIN_QUALIFY_BIT = 3;
    localparam int FIRST_SOURCE_SELECT_BIT = 2;
    localparam int FIRST_MODE_HI = 1;
    localparam int FIRST_MODE_LO = 0;
    // timer control fields
    localparam int SECOND_OVERFLOW_BIT = 7;
    localparam int SECOND_RUN_BIT = 6;
    localparam int FIRST_OVERFLOW_BIT = 5;
    localparam int FIRST_RUN_BIT = 4;
    // timer options fields
    localparam int SECOND_IRQ_POLARITY_BIT = 3;
    localparam int FIRST_IRQ_POLARITY_BIT = 2;
    localparam int SECOND_PRESCALE_BIT = 1;
    localparam int FIRST_PRESCALE_BIT = 0;
    // irq status fields
    localparam int IRQ_FIRST_OVF = 0;
    localparam int IRQ_SECOND_OVF = 1;
    localparam int IRQ_W = 2;
    // prescaled clock: system clock divided by this count
    localparam int PRESCALE_DIV = 12;
    localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_8BIT_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } dtm_mode_t;
endpackage

/* design/dtm_pin_sync.sv */
// two-stage synchroniser and falling-edge detector for one pin
`timescale 1ns/1ps
module dtm_pin_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // pin and results
    input wire logic pinIn,
    output logic pinLevel,
    output logic pinFall
);
    logic stage1Reg;
    logic stage2Reg;
    logic prevReg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stage1Reg <= 1'b1;
            stage2Reg <= 1'b1;
            prevReg <= 1'b1;
        end else begin
            stage1Reg <= pinIn;
            stage2Reg <= stage1Reg;
            prevReg <= stage2Reg;
        end
    end

    assign pinLevel = stage2Reg;
    // one pulse per sampled high-to-low step
    assign pinFall = prevReg & ~stage2Reg;
endmodule

/* design/dtm_prescaler.sv */
// divider giving a one-cycle prescaled-clock enable
`timescale 1ns/1ps
module dtm_prescaler
    import dtm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // enable out
    output logic tickPulse
);
    logic [3:0] divCount_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            divCount_reg <= '0;
        end else if (divCount_reg == PRESCALE_LAST) begin
            divCount_reg <= '0;
        end else begin
            divCount_reg <= divCount_reg + 4'd1;
        end
    end

    assign tickPulse = (divCount_reg == PRESCALE_LAST);
endmodule

/* verif/dtm_pin_model.sv */
// count pin driver standing in for the external signal sources
`timescale 1ns/1ps
module dtm_pin_model (
    // clock
    input wire logic clk_sys,
    // count pins
    output logic firstCountPin,
    output logic secondCountPin
);
    initial begin
        firstCountPin = 1'b1;
        secondCountPin = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    // up to eight falls per pin, each level held four cycles
    task automatic pulse(input int nf, input int ns);
        for (int i = 0; i < 8; i++) begin
            repeat (4) @(posedge clk_sys);
            firstCountPin <= !(i < nf);
            secondCountPin <= !(i < ns);
            repeat (4) @(posedge clk_sys);
            firstCountPin <= 1'b1;
            secondCountPin <= 1'b1;
        end
    endtask
endmodule

/* verif/dtm_dual_timer_assertions.sv */
// checker: port-level properties of the dual timer block
`timescale 1ns/1ps
module dtm_dual_timer_assertions
    import dtm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regRdData,
    // pins
    input wire logic firstCountPin,
    input wire logic secondCountPin,
    input wire logic firstExternalIrqPin,
    input wire logic secondExternalIrqPin,
    // status
    input wire logic firstTimerOverflowFlag,
    input wire logic secondTimerOverflowFlag,
    input wire logic timerIrq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    property p_reset;
        @(posedge clk_sys) disable iff (1'b0)
        sys_rst |=> regRdData == BYTE_RESET && !firstTimerOverflowFlag &&
            !secondTimerOverflowFlag && !timerIrq;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not cleared by reset");
    property p_rd_idle;
        !regRead |=> regRdData == BYTE_RESET;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_unmapped;
        regRead && regAddr == 8'h8f |=> regRdData == UNMAPPED_READ;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    sequence s_mode_wr_rd;
        regWrite && regAddr == TIMER_MODE_SELECT_OFS ##1
            regRead && regAddr == TIMER_MODE_SELECT_OFS;
    endsequence
    property p_mode_rb;
        s_mode_wr_rd |=> regRdData == $past(regWrData, 2);
    endproperty
    a_mode_rb: assert property (p_mode_rb)
        else $error("mode select readback wrong");
    property p_opt_rb;
        regWrite && regAddr == TIMER_OPTIONS_OFS ##1
            regRead && regAddr == TIMER_OPTIONS_OFS
            |=> regRdData[3:0] == $past(regWrData[3:0], 2);
    endproperty
    a_opt_rb: assert property (p_opt_rb)
        else $error("options readback wrong");
    property p_first_hold;
        firstTimerOverflowFlag && !(regWrite &&
            regAddr == TIMER_CONTROL_OFS) |=> firstTimerOverflowFlag;
    endproperty
    a_first_hold: assert property (p_first_hold)
        else $error("first flag dropped without write");
    property p_second_hold;
        secondTimerOverflowFlag && !(regWrite &&
            regAddr == TIMER_CONTROL_OFS) |=> $stable(secondTimerOverflowFlag);
    endproperty
    a_second_hold: assert property (p_second_hold)
        else $error("second flag dropped without write");
    property p_ctl_flags;
        regRead && regAddr == TIMER_CONTROL_OFS |=>
            regRdData[5] == $past(firstTimerOverflowFlag) &&
            regRdData[7] == $past(secondTimerOverflowFlag);
    endproperty
    a_ctl_flags: assert property (p_ctl_flags)
        else $error("control read disagrees with flags");
    c_first_ovf: cover property ($rose(firstTimerOverflowFlag));
    c_second_ovf: cover property ($rose(secondTimerOverflowFlag));
    c_irq: cover property ($rose(timerIrq));
endmodule
bind dtm_dual_timer dtm_dual_timer_assertions chk_u (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .firstCountPin(firstCountPin),
    .secondCountPin(secondCountPin),
    .firstExternalIrqPin(firstExternalIrqPin),
    .secondExternalIrqPin(secondExternalIrqPin),
    .firstTimerOverflowFlag(firstTimerOverflowFlag),
    .secondTimerOverflowFlag(secondTimerOverflowFlag),
    .timerIrq(timerIrq)
);

/* verif/dtm_dual_timer_test.sv */
// testbench: register-level scenarios for the dual timer block
`timescale 1ns/1ps
module dtm_dual_timer_test
    import dtm_pkg::*;
();
    localparam int RUN_D = 5;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic regWrite = 1'b0, regRead = 1'b0, rdTaken = 1'b0;
    logic firstCountPin, secondCountPin;
    logic firstExternalIrqPin = 1'b0, secondExternalIrqPin = 1'b0;
    logic firstTimerOverflowFlag, secondTimerOverflowFlag, timerIrq;
    logic [7:0] expQ[$];
    int n_mismatch = 0, checked = 0;
    int seed = 32'h572c546a;
    always #10 clk_sys = ~clk_sys;
    dtm_dual_timer dut_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .firstCountPin(firstCountPin),
        .secondCountPin(secondCountPin),
        .firstExternalIrqPin(firstExternalIrqPin),
        .secondExternalIrqPin(secondExternalIrqPin),
        .firstTimerOverflowFlag(firstTimerOverflowFlag),
        .secondTimerOverflowFlag(secondTimerOverflowFlag),
        .timerIrq(timerIrq)
    );
    dtm_pin_model pin_u (
        .clk_sys(clk_sys), .firstCountPin(firstCountPin),
        .secondCountPin(secondCountPin)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regRead <= 1'b0;
        regAddr <= a;
        regWrData <= d;
    endtask
    // expectation noted when the read is issued
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            regWrite <= 1'b0;
            regRead <= 1'b0;
        end
        @(negedge clk_sys);
    endtask
    task automatic chk(input logic got, input logic e);
        @(negedge clk_sys);
        checked++;
        if (got !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: output %b, want %b", $time, got, e);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // read data stands in the cycle after the strobe
    always @(posedge clk_sys) begin
        logic [7:0] e;
        if (rdTaken) begin
            e = expQ.pop_front();
            checked++;
            if (regRdData !== e) begin
                n_mismatch++;
                $display("unexpected at %0t: read %h, want %h", $time,
                    regRdData, e);
            end
        end
        rdTaken <= regRead;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] v, e;
        logic g, pin, pol;
        int nf, ns;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(TIMER_MODE_SELECT_OFS, 8'h00);
        rd(FIRST_TIMER_LOW_COUNT_OFS, 8'h00);
        rd(SECOND_TIMER_LOW_COUNT_OFS, 8'h00);
        rd(8'h8f, UNMAPPED_READ);
        // split mode kept off so the second timer stays still
        repeat (4) begin
            v = 8'($random(seed));
            wr(FIRST_TIMER_LOW_COUNT_OFS, v);
            rd(FIRST_TIMER_LOW_COUNT_OFS, v);
            wr(SECOND_TIMER_LOW_COUNT_OFS, ~v);
            rd(SECOND_TIMER_LOW_COUNT_OFS, ~v);
            wr(TIMER_MODE_SELECT_OFS, v & 8'hfe);
            rd(TIMER_MODE_SELECT_OFS, v & 8'hfe);
        end
        // gate, pin level and polarity in every combination
        for (int i = 0; i < 8; i++) begin
            g = i[0];
            pin = i[1];
            pol = i[2];
            firstExternalIrqPin <= pin;
            secondExternalIrqPin <= pin;
            wr(TIMER_OPTIONS_OFS, {4'h0, pol, pol, 2'b11});
            rd(TIMER_OPTIONS_OFS, {4'h0, pol, pol, 2'b11});
            wr(TIMER_MODE_SELECT_OFS, {g, 3'b001, g, 3'b001});
            wr(FIRST_TIMER_LOW_COUNT_OFS, 8'h00);
            wr(SECOND_TIMER_LOW_COUNT_OFS, 8'h00);
            wr(TIMER_CONTROL_OFS, 8'h50);
            idle(RUN_D - 1);
            wr(TIMER_CONTROL_OFS, 8'h00);
            e = (g && pin != pol) ? 8'h00 : 8'(RUN_D);
            rd(FIRST_TIMER_LOW_COUNT_OFS, e);
            rd(SECOND_TIMER_LOW_COUNT_OFS, e);
        end
        // counter source: only pin falls count
        nf = $random(seed) & 7;
        ns = $random(seed) & 7;
        wr(TIMER_MODE_SELECT_OFS, 8'h55);
        wr(FIRST_TIMER_LOW_COUNT_OFS, 8'h00);
        wr(SECOND_TIMER_LOW_COUNT_OFS, 8'h00);
        wr(TIMER_CONTROL_OFS, 8'h50);
        idle(1);
        pin_u.pulse(nf, ns);
        idle(6);
        wr(TIMER_CONTROL_OFS, 8'h00);
        rd(FIRST_TIMER_LOW_COUNT_OFS, 8'(nf));
        rd(SECOND_TIMER_LOW_COUNT_OFS, 8'(ns));
        // auto-reload wrap from fc, high byte as reload
        wr(TIMER_MODE_SELECT_OFS, 8'h02);
        wr(FIRST_TIMER_HIGH_COUNT_OFS, 8'hf0);
        wr(FIRST_TIMER_LOW_COUNT_OFS, 8'hfc);
        wr(TIMER_CONTROL_OFS, 8'h10);
        idle(5);
        wr(TIMER_CONTROL_OFS, 8'h20);
        idle(1);
        chk(firstTimerOverflowFlag, 1'b1);
        rd(FIRST_TIMER_LOW_COUNT_OFS, 8'hf2);
        rd(FIRST_TIMER_HIGH_COUNT_OFS, 8'hf0);
        rd(TIMER_CONTROL_OFS, 8'h20);
        rd(IRQ_STATUS_OFS, 8'h01);
        idle(1);
        chk(timerIrq, 1'b0);
        wr(IRQ_MASK_OFS, 8'h01);
        idle(2);
        chk(timerIrq, 1'b1);
        wr(IRQ_STATUS_OFS, 8'h01);
        idle(2);
        chk(timerIrq, 1'b0);
        // 13-bit: low five bits carry into the high byte
        wr(TIMER_CONTROL_OFS, 8'h00);
        wr(TIMER_MODE_SELECT_OFS, 8'h00);
        wr(FIRST_TIMER_LOW_COUNT_OFS, 8'hfe);
        wr(FIRST_TIMER_HIGH_COUNT_OFS, 8'hff);
        wr(TIMER_CONTROL_OFS, 8'h10);
        idle(2);
        wr(TIMER_CONTROL_OFS, 8'h20);
        idle(1);
        chk(firstTimerOverflowFlag, 1'b1);
        rd(FIRST_TIMER_LOW_COUNT_OFS, 8'he1);
        rd(FIRST_TIMER_HIGH_COUNT_OFS, 8'h00);
        // split: high byte runs on the second run bit
        wr(TIMER_CONTROL_OFS, 8'h00);
        wr(TIMER_MODE_SELECT_OFS, 8'h13);
        wr(SECOND_TIMER_LOW_COUNT_OFS, 8'h00);
        wr(FIRST_TIMER_LOW_COUNT_OFS, 8'h00);
        wr(FIRST_TIMER_HIGH_COUNT_OFS, 8'hfe);
        wr(TIMER_CONTROL_OFS, 8'h40);
        idle(3);
        wr(TIMER_CONTROL_OFS, 8'h80);
        idle(1);
        chk(secondTimerOverflowFlag, 1'b1);
        chk(firstTimerOverflowFlag, 1'b0);
        rd(FIRST_TIMER_HIGH_COUNT_OFS, 8'h02);
        rd(FIRST_TIMER_LOW_COUNT_OFS, 8'h00);
        rd(SECOND_TIMER_LOW_COUNT_OFS, 8'h0c);
        idle(3);
        final_report();
    end
endmodule
